// ===== spc_pkg.sv
// Constants, field positions and types shared by the serial port configuration block
package spc_pkg;
  localparam int SPC_ADDR_W = 13;
  localparam int SPC_DATA_W = 8;
  localparam logic [12:0] SPC_CFG_ADDR = 13'h000;
  localparam logic [12:0] SPC_RBSEL_ADDR = 13'h004;
  localparam logic [12:0] SPC_MEM_BASE = 13'h010;
  localparam int SPC_MEM_DEPTH = 16;
  localparam int SPC_OUT_EN_BIT = 7;
  localparam int SPC_LSB_FIRST_BIT = 6;
  localparam int SPC_SOFT_RST_BIT = 5;
  localparam int SPC_RBSEL_BIT = 0;
  localparam int SPC_RD_FLAG_BIT = 15;
  localparam logic SPC_OUT_EN_RST = 1'b0;
  localparam logic SPC_LSB_FIRST_RST = 1'b0;
  localparam logic SPC_RBSEL_RST = 1'b0;
  localparam logic [7:0] SPC_MEM_RST = 8'h00;
  localparam logic [3:0] SPC_INSTR_LAST = 4'hf;
  localparam logic [3:0] SPC_BYTE_LAST = 4'h7;
  typedef enum logic [1:0] {SPC_IDLE, SPC_INSTR, SPC_DATA} spc_state_type;
endpackage

// ===== spc_reg_bank.sv
// Buffered and active copies of the general device registers
`timescale 1ns/1ns
module spc_reg_bank import spc_pkg::*; #(
  parameter int DEPTH = SPC_MEM_DEPTH,
  parameter int IW = 4,
  parameter logic [7:0] RST_VAL = SPC_MEM_RST
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [IW-1:0] i_idx,
  input wire logic [7:0] i_wdata,
  input wire logic i_update,
  input wire logic i_sel_active,
  output logic [7:0] o_rdata
);
  logic [7:0] buf_q [DEPTH];
  logic [7:0] buf_d [DEPTH];
  logic [7:0] act_q [DEPTH];
  logic [7:0] act_d [DEPTH];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    buf_d = buf_q;
    act_d = act_q;
    if (i_update) begin
      act_d = buf_q;
    end
    if (i_we) begin
      buf_d[i_idx] = i_wdata;
    end
    if (i_clear) begin
      for (int k = 0; k < DEPTH; k++) begin
        buf_d[k] = RST_VAL;
        act_d[k] = RST_VAL;
      end
    end
    rdata_d = i_sel_active ? act_q[i_idx] : buf_q[i_idx];
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < DEPTH; k++) begin
        buf_q[k] <= SPC_MEM_RST;
        act_q[k] <= SPC_MEM_RST;
      end
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      buf_q <= buf_d;
      act_q <= act_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
endmodule // spc_reg_bank

// ===== spc_serial_port_cfg.sv
// Serial control port slave with its configuration and readback-select registers
// How it works
// - With the output pin enable bit low, reads go out on the shared data pin outside two-wire mode, and the serial output pin stays undriven.
// - With the output pin enable bit high, writes still arrive on the shared data pin and, outside two-wire mode, reads leave only on the serial output pin.
// - With the bit-order bit low, bits move MSB first and the address counts down after each byte.
// - With the bit-order bit high, bits move LSB first and the address counts up after each byte.
// - In two-wire mode the bit-order bit has no effect on transfers.
// - Writing 1 to the soft-reset bit returns the configuration, readback-select and general registers to their defaults, and the bit never holds.
// - The readback-select bit picks the buffered copy (0) or the active copy (1) for reads.
`timescale 1ns/1ns
module spc_serial_port_cfg import spc_pkg::*; #(
  parameter int DEPTH = SPC_MEM_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_i2c_mode,
  input wire logic i_update,
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_serial_output_pin,
  output logic o_serial_output_pin_oe,
  output logic o_output_pin_enable_bit,
  output logic o_lsb_first,
  output logic o_readback_active,
  output logic o_soft_rst_pulse
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  function automatic logic in_mem(input logic [12:0] a);
    in_mem = (a >= SPC_MEM_BASE) && (a < SPC_MEM_BASE + 13'(DEPTH));
  endfunction

  logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, dio_s1, dio_s2;
  spc_state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [12:0] addr_q, addr_d;
  logic rd_q, rd_d, drive_q, drive_d, dout_q, dout_d;
  logic ld1_q, ld1_d, ld2_q, ld2_d;
  logic [7:0] tx_q, tx_d;
  logic out_en_q, out_en_d, lsb_q, lsb_d, rbsel_q, rbsel_d, clr_q, clr_d;
  logic rise, fall, eff_lsb, mem_we;
  logic [15:0] nsh;
  logic [7:0] mem_rdata, rd_byte, cfg_rd;

  // Sampling sclk, select and data through the same depth keeps them aligned
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      dio_s1 <= 1'b0;
      dio_s2 <= 1'b0;
    end else if (i_ce) begin
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= i_cs_b;
      cs_s2 <= cs_s1;
      dio_s1 <= i_sdio;
      dio_s2 <= dio_s1;
    end
  end

  assign rise = sclk_s2 & ~sclk_s3;
  assign fall = ~sclk_s2 & sclk_s3;
  assign eff_lsb = lsb_q & ~i_i2c_mode;

  // Mirror nibble is rebuilt from the live bits, so reads always decode the same either way
  assign cfg_rd = {out_en_q, lsb_q, 1'b0, 1'b0, 1'b0, 1'b0, lsb_q, out_en_q};

  always_comb begin
    if (addr_q == SPC_CFG_ADDR) begin
      rd_byte = cfg_rd;
    end else if (addr_q == SPC_RBSEL_ADDR) begin
      rd_byte = {7'h00, rbsel_q};
    end else if (in_mem(addr_q)) begin
      rd_byte = mem_rdata;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    rd_d = rd_q;
    drive_d = drive_q;
    dout_d = dout_q;
    tx_d = tx_q;
    ld1_d = 1'b0;
    ld2_d = ld1_q;
    out_en_d = out_en_q;
    lsb_d = lsb_q;
    rbsel_d = rbsel_q;
    clr_d = 1'b0;
    mem_we = 1'b0;
    nsh = sh_q;
    if (ld2_q) begin
      tx_d = rd_byte;
    end
    if (cs_s2) begin
      state_d = SPC_IDLE;
      cnt_d = 4'h0;
      drive_d = 1'b0;
    end else begin
      case (state_q)
        SPC_IDLE: begin
          state_d = SPC_INSTR;
          cnt_d = 4'h0;
        end
        SPC_INSTR: begin
          if (rise) begin
            nsh = eff_lsb ? {dio_s2, sh_q[15:1]} : {sh_q[14:0], dio_s2};
            sh_d = nsh;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == SPC_INSTR_LAST) begin
              state_d = SPC_DATA;
              cnt_d = 4'h0;
              addr_d = nsh[12:0];
              rd_d = nsh[SPC_RD_FLAG_BIT];
              ld1_d = nsh[SPC_RD_FLAG_BIT];
            end
          end
        end
        SPC_DATA: begin
          if (rise) begin
            nsh = eff_lsb ? {8'h00, dio_s2, sh_q[7:1]} : {8'h00, sh_q[6:0], dio_s2};
            sh_d = nsh;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == SPC_BYTE_LAST) begin
              cnt_d = 4'h0;
              addr_d = eff_lsb ? 13'(addr_q + 13'h1) : 13'(addr_q - 13'h1);
              ld1_d = rd_q;
              if (!rd_q) begin
                if (addr_q == SPC_CFG_ADDR) begin
                  if (nsh[SPC_SOFT_RST_BIT]) begin
                    clr_d = 1'b1;
                  end else begin
                    out_en_d = nsh[SPC_OUT_EN_BIT];
                    lsb_d = nsh[SPC_LSB_FIRST_BIT];
                  end
                end else if (addr_q == SPC_RBSEL_ADDR) begin
                  rbsel_d = nsh[SPC_RBSEL_BIT];
                end else if (in_mem(addr_q)) begin
                  mem_we = 1'b1;
                end
              end
            end
          end
          // Read bits change on falling edges so the host can sample on the next rise
          if (fall && rd_q) begin
            dout_d = eff_lsb ? tx_q[0] : tx_q[7];
            tx_d = eff_lsb ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
            drive_d = ~i_i2c_mode;
          end
        end
        default: begin
          state_d = SPC_IDLE;
        end
      endcase
    end
    // Soft reset is never stored, so the bit is clear on the very next read
    if (clr_d) begin
      out_en_d = SPC_OUT_EN_RST;
      lsb_d = SPC_LSB_FIRST_RST;
      rbsel_d = SPC_RBSEL_RST;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= SPC_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      addr_q <= 13'h0000;
      rd_q <= 1'b0;
      drive_q <= 1'b0;
      dout_q <= 1'b0;
      tx_q <= 8'h00;
      ld1_q <= 1'b0;
      ld2_q <= 1'b0;
      out_en_q <= SPC_OUT_EN_RST;
      lsb_q <= SPC_LSB_FIRST_RST;
      rbsel_q <= SPC_RBSEL_RST;
      clr_q <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      drive_q <= drive_d;
      dout_q <= dout_d;
      tx_q <= tx_d;
      ld1_q <= ld1_d;
      ld2_q <= ld2_d;
      out_en_q <= out_en_d;
      lsb_q <= lsb_d;
      rbsel_q <= rbsel_d;
      clr_q <= clr_d;
    end
  end

  spc_reg_bank #(.DEPTH(DEPTH), .IW(IW), .RST_VAL(SPC_MEM_RST)) u_bank (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_clear(clr_d),
    .i_we(mem_we),
    .i_idx(IW'(addr_q - SPC_MEM_BASE)),
    .i_wdata(nsh[7:0]),
    .i_update(i_update),
    .i_sel_active(rbsel_q),
    .o_rdata(mem_rdata)
  );

  assign o_sdio = dout_q;
  assign o_sdio_oe = drive_q & ~out_en_q;
  assign o_serial_output_pin = dout_q;
  assign o_serial_output_pin_oe = drive_q & out_en_q;
  assign o_output_pin_enable_bit = out_en_q;
  assign o_lsb_first = lsb_q;
  assign o_readback_active = rbsel_q;
  assign o_soft_rst_pulse = clr_q;
endmodule // spc_serial_port_cfg

// ===== spc_serial_port_cfg_asserts.sv
// Concurrent checks on the serial port configuration block ports
`timescale 1ns/1ns
module spc_serial_port_cfg_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_cs_b,
  input wire logic i_i2c_mode,
  input wire logic o_sdio_oe,
  input wire logic o_serial_output_pin_oe,
  input wire logic o_output_pin_enable_bit,
  input wire logic o_lsb_first,
  input wire logic o_readback_active,
  input wire logic o_soft_rst_pulse
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Long enough for the synchronisers to see the frame closed
  sequence idle_s;
    i_cs_b [*8];
  endsequence
  oe_excl_a:
    assert property (!(o_sdio_oe && o_serial_output_pin_oe)) else $error("both data pins driven");
  so_hiz_a:
    assert property (!o_output_pin_enable_bit |-> !o_serial_output_pin_oe) else $error("output pin driven");
  sdio_quiet_a:
    assert property (o_output_pin_enable_bit |-> !o_sdio_oe) else $error("shared pin driven");
  idle_hiz_a:
    assert property (idle_s |-> !o_sdio_oe && !o_serial_output_pin_oe) else $error("driven while idle");
  cfg_hold_a:
    assert property (idle_s |=> $stable(o_lsb_first) && $stable(o_output_pin_enable_bit)
      && $stable(o_readback_active)) else $error("config moved while idle");
  i2c_nodrive_a:
    assert property (i_i2c_mode |-> !o_sdio_oe && !o_serial_output_pin_oe) else $error("drive in two-wire mode");
  srst_clear_a:
    assert property (o_soft_rst_pulse |-> !o_lsb_first && !o_output_pin_enable_bit && !o_readback_active)
      else $error("soft reset left bits set");
  srst_once_a:
    assert property (o_soft_rst_pulse |=> !o_soft_rst_pulse) else $error("soft reset did not clear");
endmodule // spc_serial_port_cfg_asserts
bind spc_serial_port_cfg spc_serial_port_cfg_asserts i_asserts (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
  .i_cs_b(i_cs_b), .i_i2c_mode(i_i2c_mode), .o_sdio_oe(o_sdio_oe), .o_serial_output_pin_oe(o_serial_output_pin_oe),
  .o_output_pin_enable_bit(o_output_pin_enable_bit), .o_lsb_first(o_lsb_first),
  .o_readback_active(o_readback_active), .o_soft_rst_pulse(o_soft_rst_pulse));

// ===== spc_host_model.sv
// Host controller model for the serial control port
`timescale 1ns/1ns
module spc_host_model (
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_sdio,
  output logic o_sdio_oe,
  input wire logic i_sdio,
  input wire logic i_so
);
  logic lsb = 1'b0;
  logic uni = 1'b0;
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdio = 1'b0;
    o_sdio_oe = 1'b0;
  end
  // Read bits are taken late in the high phase, after the synchronised answer settles
  task automatic frame(input logic [15:0] ins, input int nb, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] fr;
    logic [31:0] rv;
    fr = {wd, ins};
    rv = 32'h00000000;
    o_cs_b = 1'b0;
    o_sdio_oe = 1'b1;
    #80;
    for (int k = 0; k < 16 + 8 * nb; k++) begin
      int p;
      p = k < 16 ? (lsb ? k : 15 - k) : 16 + 8 * ((k - 16) / 8) + (lsb ? k % 8 : 7 - k % 8);
      o_sclk = 1'b0;
      o_sdio_oe = !(ins[15] && k >= 16);
      o_sdio = fr[p];
      #80 o_sclk = 1'b1;
      #70 rv[p] = uni ? i_so : i_sdio;
      #10;
    end
    o_sclk = 1'b0;
    #80 o_cs_b = 1'b1;
    o_sdio_oe = 1'b0;
    rd = rv[31:16];
    #200;
  endtask
endmodule // spc_host_model

// ===== spc_serial_port_cfg_bench.sv
// Self-checking bench for the serial port configuration block
`timescale 1ns/1ns
module spc_serial_port_cfg_bench;
  import spc_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_i2c_mode = 1'b0;
  logic i_update = 1'b0;
  logic sclk, cs_b, h_sdio, h_oe, o_sdio, o_sdio_oe, so, so_oe, en_bit, lsb_bit, rb_act, srst;
  wire logic sdio_w;
  wire logic so_w;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_srst = 0;
  logic [15:0] rd;
  always #10 i_sys_clk = ~i_sys_clk;
  // A released line shows the inverse of the last bit so a stale value never matches
  assign sdio_w = o_sdio_oe ? o_sdio : h_oe ? h_sdio : ~o_sdio;
  assign so_w = so_oe ? so : ~so;
  spc_serial_port_cfg #(.DEPTH(16)) i_spc_serial_port_cfg (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
    .i_i2c_mode(i_i2c_mode), .i_update(i_update), .i_sclk(sclk), .i_cs_b(cs_b), .i_sdio(sdio_w),
    .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .o_serial_output_pin(so), .o_serial_output_pin_oe(so_oe),
    .o_output_pin_enable_bit(en_bit), .o_lsb_first(lsb_bit), .o_readback_active(rb_act), .o_soft_rst_pulse(srst));
  spc_host_model i_spc_host_model (.o_sclk(sclk), .o_cs_b(cs_b), .o_sdio(h_sdio), .o_sdio_oe(h_oe),
    .i_sdio(sdio_w), .i_so(so_w));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    i_spc_host_model.frame({3'b000, a}, 1, {8'h00, d}, rd);
  endtask
  task automatic rd1(input logic [12:0] a, input logic [7:0] e);
    i_spc_host_model.frame({3'b100, a}, 1, 16'h0000, rd);
    chk({8'h00, rd[7:0]}, {8'h00, e});
  endtask
  task automatic upd;
    @(posedge i_sys_clk);
    #1 i_update = 1'b1;
    @(posedge i_sys_clk);
    #1 i_update = 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cycles++;
    if (srst === 1'b1) begin
      n_srst++;
    end
    if (cycles == 20000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    #1 chk({11'h000, o_sdio_oe, so_oe, en_bit, lsb_bit, rb_act}, 16'h0000);
    rd1(SPC_CFG_ADDR, 8'h00);
    i_spc_host_model.frame(16'h0011, 2, 16'h3ca5, rd);
    i_spc_host_model.frame(16'h8011, 2, 16'h0000, rd);
    chk(rd, 16'h3ca5);
    rd1(13'h010, 8'h3c);
    wr(13'h100, 8'h77);
    rd1(13'h100, 8'h00);
    wr(SPC_RBSEL_ADDR, 8'hff);
    rd1(SPC_RBSEL_ADDR, 8'h01);
    rd1(13'h010, 8'h00);
    upd();
    rd1(13'h010, 8'h3c);
    wr(SPC_CFG_ADDR, 8'h81);
    i_spc_host_model.uni = 1'b1;
    rd1(13'h011, 8'ha5);
    rd1(SPC_CFG_ADDR, 8'h81);
    wr(SPC_CFG_ADDR, 8'h42);
    i_spc_host_model.uni = 1'b0;
    i_spc_host_model.lsb = 1'b1;
    i_spc_host_model.frame(16'h0012, 2, 16'h6699, rd);
    // Reads still return the active copy, so publish the new writes first
    upd();
    rd1(13'h013, 8'h66);
    rd1(SPC_CFG_ADDR, 8'h42);
    @(posedge i_sys_clk);
    #1 i_i2c_mode = 1'b1;
    i_spc_host_model.lsb = 1'b0;
    wr(13'h014, 8'h5a);
    i_spc_host_model.frame(16'h8014, 1, 16'h0000, rd);
    @(posedge i_sys_clk);
    #1 i_i2c_mode = 1'b0;
    i_spc_host_model.lsb = 1'b1;
    upd();
    rd1(13'h014, 8'h5a);
    wr(SPC_CFG_ADDR, 8'h24);
    i_spc_host_model.lsb = 1'b0;
    chk({13'h0000, en_bit, lsb_bit, rb_act}, 16'h0000);
    chk(16'(n_srst), 16'h0001);
    rd1(13'h012, 8'h00);
    rd1(SPC_CFG_ADDR, 8'h00);
    end_sim();
  end
endmodule // spc_serial_port_cfg_bench
